// file: uteb_pkg.sv
// Shared constants, state types and helper functions of the serial transmit-enable
// and fractional bit-timing block.
// Assumes a single system clock; the baud source arrives as a one-cycle enable.
package uteb_pkg;

    // Widths of the divisor bytes, the modulation pattern and one character.
    localparam int BYTE_W = 8;
    localparam int DIV_W = 16;
    localparam int FRAME_W = 12;
    localparam int BITCNT_W = 4;
    localparam int MODIDX_W = 3;

    // Values after reset.
    localparam logic LINE_IDLE = 1'b1;
    localparam logic READY_RST = 1'b1;
    localparam logic EMPTY_RST = 1'b1;
    localparam logic [DIV_W-1:0] CNT_RST = 16'h0001;

    // Transmit shifter states.
    typedef enum logic [0:0] {TX_IDLE, TX_ACTIVE} uteb_tx_state_t;

    // Receiver states.
    typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_PUSH} uteb_rx_state_t;

    // Length of one half of a bit in baud ticks: the first half is the integer half of the
    // divisor plus the modulation bit, the second half is the remainder of the divisor.
    function automatic logic [DIV_W-1:0] half_len(input logic [DIV_W-1:0] n,
                                                  input logic m, input logic second);
        logic [DIV_W-1:0] h;
        h = second ? (n - {1'b0, n[DIV_W-1:1]}) : ({1'b0, n[DIV_W-1:1]} + {15'h0000, m});
        if (h == 16'h0000) begin
            h = 16'h0001;
        end
        return h;
    endfunction : half_len

    // Number of serial bits in a frame: start, data, optional parity, one or two stops.
    function automatic logic [BITCNT_W-1:0] frame_bits(input logic len7, input logic par_en,
                                                      input logic two_stop);
        return 4'h1 + (len7 ? 4'h7 : 4'h8) + {3'h0, par_en} + (two_stop ? 4'h2 : 4'h1);
    endfunction : frame_bits

    // Serial frame, least significant bit sent first; unused positions are stop level.
    function automatic logic [FRAME_W-1:0] frame_build(input logic [BYTE_W-1:0] d,
            input logic len7, input logic par_en, input logic par_even);
        logic [FRAME_W-1:0] f;
        logic [BYTE_W-1:0] dm;
        f = 12'hFFF;
        dm = len7 ? {1'b0, d[6:0]} : d;
        f[0] = 1'b0;
        f[8:1] = dm;
        if (len7) begin
            f[8] = 1'b1;
        end
        if (par_en) begin
            f[len7 ? 8 : 9] = par_even ? (^dm) : ~(^dm);
        end
        return f;
    endfunction : frame_build

    // Majority of three samples.
    function automatic logic maj3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : maj3

endpackage : uteb_pkg

// file: uteb_stream_if.sv
// Valid/ready carrier for received characters between the receiver and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface uteb_stream_if #(parameter int WIDTH = 8);
    logic valid; // Word offered.
    logic ready; // Word can be taken.
    logic [WIDTH-1:0] data; // Word itself.
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : uteb_stream_if

// file: uteb_fifo2.sv
// Two-entry buffer for received characters, all outputs taken from flip-flops.
// Assumes a sink that may hold ready low for any length of time.
`timescale 1ns/1ps
module uteb_fifo2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    uteb_stream_if.snk in_s,
    uteb_stream_if.src out_s
);
    logic [WIDTH-1:0] head; // Entry shown to the sink.
    logic [WIDTH-1:0] tail; // Second entry, filled while the head is held.
    logic head_valid; // Head holds a word.
    logic tail_valid; // Tail holds a word, so the buffer is full.
    logic push;
    logic pop;

    assign push = in_s.valid && !tail_valid;
    assign pop = head_valid && out_s.ready;
    assign in_s.ready = !tail_valid;
    assign out_s.valid = head_valid;
    assign out_s.data = head;

    // Moves words in and out; a full buffer refuses the source until the sink drains it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head <= '0;
            tail <= '0;
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
        end else if (push && pop) begin
            // The tail is empty here, so the new word goes straight to the head.
            head <= in_s.data;
        end else if (pop) begin
            // The tail moves forward, or the buffer becomes empty.
            head <= tail;
            head_valid <= tail_valid;
            tail_valid <= 1'b0;
        end else if (push) begin
            if (!head_valid) begin
                head <= in_s.data;
                head_valid <= 1'b1;
            end else begin
                tail <= in_s.data;
                tail_valid <= 1'b1;
            end
        end
    end

endmodule : uteb_fifo2

// file: uteb_top.sv
// Transmit-enable control, transmit shifter and receive bit timing of a serial port,
// with a fractional divider driven by a selectable baud source.
// Assumes all inputs are synchronous to CLOCK and the divisor is at least 4.
`timescale 1ns/1ps

// Functional notes
// - enabled transmitter sends each written character
// - buffer moves to shifter on next bit tick
// - disabling still finishes buffered and active frames
// - disabled writes stay buffered until re-enabled
// - re-enabling loads a waiting character at once if shifter idle
// - three samples around bit middle, majority wins
// - sixteen-bit divisor from high and low bytes
// - half-divisor counter reloaded for each bit half
// - set modulation bit lengthens bit by one
// - modulation bits step per serial bit, LSB first
// - modulation pattern wraps after eight bits
// - start bit tested mid-bit, then full-bit steps
// - ready flag set when free, cleared on write
module uteb_top (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic BAUD_SOURCE_SELECT,
    input wire logic BAUD_EXT_TICK,
    input wire logic [uteb_pkg::BYTE_W-1:0] DIVISOR_LOW_BYTE,
    input wire logic [uteb_pkg::BYTE_W-1:0] DIVISOR_HIGH_BYTE,
    input wire logic [uteb_pkg::BYTE_W-1:0] MODULATION_PATTERN,
    input wire logic DATA_LEN7,
    input wire logic PARITY_ENABLE,
    input wire logic PARITY_EVEN,
    input wire logic TWO_STOP,
    input wire logic TX_ENABLE_BIT,
    input wire logic TXBUF_WRITE,
    input wire logic [uteb_pkg::BYTE_W-1:0] TXBUF_DATA,
    output logic TX_BUFFER_READY_FLAG,
    output logic TX_EMPTY_FLAG,
    output logic SERIAL_TX_PIN,
    input wire logic SERIAL_RX_PIN,
    output logic [uteb_pkg::BYTE_W-1:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY
);
    import uteb_pkg::*;

    logic baud_tick; // One baud source period has passed.
    logic [DIV_W-1:0] divisor_value; // Whole baud ticks per bit.
    logic [FRAME_W-1:0] next_frame; // Frame built from the holding buffer.
    logic [BITCNT_W-1:0] nbits; // Serial bits per frame.

    // Baud source is either the system clock itself or the external enable pulse.
    assign baud_tick = BAUD_SOURCE_SELECT ? BAUD_EXT_TICK : 1'b1;
    assign divisor_value = {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE};
    assign nbits = frame_bits(DATA_LEN7, PARITY_ENABLE, TWO_STOP);

    // ---------------- Transmit side ----------------
    uteb_tx_state_t tx_state; // Shifter idle or sending.
    logic [BYTE_W-1:0] tx_holding_buffer; // Character written by software.
    logic hold_full; // Holding buffer holds an unsent character.
    logic hold_commit; // Character was seen while enabled and must be sent.
    logic tx_en_q; // Enable as seen one cycle ago.
    logic [FRAME_W-1:0] tx_shift; // Bit 0 is the bit on the line.
    logic [BITCNT_W-1:0] tx_left; // Bits of the frame still to finish.
    logic [MODIDX_W-1:0] tx_idx; // Modulation bit of the current serial bit.
    logic [DIV_W-1:0] tx_cnt; // Ticks left in the current half.
    logic tx_half; // Second half of the bit.
    logic tx_bit_end; // Last tick of a bit: the bit tick.
    logic tx_half_end; // Last tick of the first half.
    logic en_rise; // Enable has just been set.
    logic hold_go; // Holding buffer may move to the shifter.
    logic tx_load; // Character moves into the shifter now.
    logic [MODIDX_W-1:0] next_tx_idx;

    assign tx_bit_end = baud_tick && (tx_cnt <= 16'h0001) && tx_half;
    assign tx_half_end = baud_tick && (tx_cnt <= 16'h0001) && !tx_half;
    assign en_rise = TX_ENABLE_BIT && !tx_en_q;
    assign hold_go = hold_full && (TX_ENABLE_BIT || hold_commit);
    // Load on a bit tick with the shifter empty or emptying, or at once on re-enable with the shifter idle.
    assign tx_load = hold_go && ((tx_state == TX_IDLE && (tx_bit_end || en_rise))
        || (tx_state == TX_ACTIVE && tx_bit_end && tx_left == 4'h1));
    assign next_tx_idx = (tx_state == TX_IDLE) ? 3'h0 : tx_idx + 3'h1;
    assign next_frame = frame_build(tx_holding_buffer, DATA_LEN7, PARITY_ENABLE, PARITY_EVEN);

    // Remembers the enable to spot the moment it is set again.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= TX_ENABLE_BIT;
        end
    end

    // Holding buffer; a write in the same cycle as a load is kept, since the load took
    // the older character.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_holding_buffer <= '0;
            hold_full <= 1'b0;
            hold_commit <= 1'b0;
        end else if (TXBUF_WRITE) begin
            tx_holding_buffer <= TXBUF_DATA;
            hold_full <= 1'b1;
            hold_commit <= TX_ENABLE_BIT;
        end else if (tx_load) begin
            hold_full <= 1'b0;
            hold_commit <= 1'b0;
        end else if (TX_ENABLE_BIT && hold_full) begin
            // A waiting character becomes due once the transmitter is enabled.
            hold_commit <= 1'b1;
        end
    end

    // Ready and empty status; the write clears ready before any load can set it.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TX_BUFFER_READY_FLAG <= READY_RST;
            TX_EMPTY_FLAG <= EMPTY_RST;
        end else begin
            if (TXBUF_WRITE) begin
                TX_BUFFER_READY_FLAG <= 1'b0;
            end else if (tx_load) begin
                TX_BUFFER_READY_FLAG <= 1'b1;
            end
            // Empty shows the state of the previous cycle.
            TX_EMPTY_FLAG <= (tx_state == TX_IDLE) && !hold_full;
        end
    end

    // Transmit bit timer; runs free while idle so that bit ticks keep coming.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_cnt <= CNT_RST;
            tx_half <= 1'b0;
            tx_idx <= '0;
        end else if (tx_load) begin
            // Every frame starts fresh on modulation bit zero.
            tx_cnt <= half_len(divisor_value, MODULATION_PATTERN[0], 1'b0);
            tx_half <= 1'b0;
            tx_idx <= '0;
        end else if (baud_tick) begin
            if (tx_cnt > 16'h0001) begin
                tx_cnt <= tx_cnt - 16'h0001;
            end else if (!tx_half) begin
                // Second half reloads from the divisor.
                tx_cnt <= half_len(divisor_value, 1'b0, 1'b1);
                tx_half <= 1'b1;
            end else begin
                // Next bit takes the next modulation bit.
                tx_cnt <= half_len(divisor_value, MODULATION_PATTERN[next_tx_idx], 1'b0);
                tx_half <= 1'b0;
                tx_idx <= next_tx_idx;
            end
        end
    end

    // Shifter and line driver; clearing the enable never cuts an active frame short.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_state <= TX_IDLE;
            tx_shift <= '1;
            tx_left <= '0;
            SERIAL_TX_PIN <= LINE_IDLE;
        end else if (tx_load) begin
            tx_state <= TX_ACTIVE;
            tx_shift <= next_frame;
            tx_left <= nbits;
            SERIAL_TX_PIN <= next_frame[0];
        end else if (tx_state == TX_ACTIVE && tx_bit_end) begin
            if (tx_left == 4'h1) begin
                tx_state <= TX_IDLE;
                SERIAL_TX_PIN <= LINE_IDLE;
            end else begin
                tx_shift <= {1'b1, tx_shift[FRAME_W-1:1]};
                tx_left <= tx_left - 4'h1;
                SERIAL_TX_PIN <= tx_shift[1];
            end
        end
    end

    // ---------------- Receive side ----------------
    uteb_rx_state_t rx_state; // Receiver state.
    logic [DIV_W-1:0] rx_cnt; // Ticks left in the current half.
    logic rx_half; // Second half of the bit.
    logic [MODIDX_W-1:0] rx_idx; // Modulation bit of the current serial bit.
    logic [DIV_W-1:0] rx_pos; // Ticks since the bit began.
    logic [1:0] rx_votes; // First two samples of the bit.
    logic rx_bit_val; // Majority value of the bit.
    logic [BITCNT_W-1:0] rx_bit_no; // Serial bit within the frame, 0 is start.
    logic [BYTE_W-1:0] rx_word; // Assembled character.
    logic rx_bit_end; // Last tick of the received bit.
    logic [DIV_W-1:0] rx_mid; // Integer half of the divisor.
    logic [DIV_W-1:0] rx_pos_next;
    logic rx_samp; // One of the three sample points.
    logic rx_third; // Third sample point.
    logic rx_maj; // Majority including the sample being taken.
    logic [MODIDX_W-1:0] next_rx_idx;

    uteb_stream_if #(.WIDTH(BYTE_W)) rx_in ();
    uteb_stream_if #(.WIDTH(BYTE_W)) rx_out ();

    assign rx_mid = {1'b0, divisor_value[DIV_W-1:1]};
    assign rx_pos_next = rx_pos + 16'h0001;
    assign rx_bit_end = baud_tick && (rx_cnt <= 16'h0001) && rx_half && rx_state == RX_BITS;
    assign rx_samp = baud_tick && rx_state == RX_BITS && (rx_pos_next == rx_mid - 16'h0001
        || rx_pos_next == rx_mid || rx_pos_next == rx_mid + 16'h0001);
    assign rx_third = rx_samp && rx_pos_next == rx_mid + 16'h0001;
    assign rx_maj = maj3(rx_votes[1], rx_votes[0], SERIAL_RX_PIN);
    assign next_rx_idx = rx_idx + 3'h1;
    assign rx_in.valid = (rx_state == RX_PUSH);
    assign rx_in.data = rx_word;
    assign rx_out.ready = RX_READY;
    assign RX_DATA = rx_out.data;
    assign RX_VALID = rx_out.valid;

    // Receive timer, sample points and frame assembly.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_state <= RX_IDLE;
            rx_cnt <= CNT_RST;
            rx_half <= 1'b0;
            rx_idx <= '0;
            rx_pos <= '0;
            rx_votes <= '0;
            rx_bit_val <= 1'b1;
            rx_bit_no <= '0;
            rx_word <= '0;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    // A low line on a baud tick is taken as the start edge.
                    if (baud_tick && !SERIAL_RX_PIN) begin
                        rx_state <= RX_BITS;
                        rx_cnt <= half_len(divisor_value, MODULATION_PATTERN[0], 1'b0);
                        rx_half <= 1'b0;
                        rx_idx <= '0;
                        rx_pos <= '0;
                        rx_bit_no <= '0;
                        rx_word <= '0;
                    end
                end
                RX_BITS: begin
                    if (rx_samp) begin
                        rx_votes <= {rx_votes[0], SERIAL_RX_PIN};
                    end
                    if (rx_third) begin
                        rx_bit_val <= rx_maj;
                    end
                    if (rx_third && rx_bit_no == 4'h0 && rx_maj) begin
                        // A start bit that is high in its middle was noise.
                        rx_state <= RX_IDLE;
                    end else if (rx_bit_end) begin
                        // Next bit follows one modulated bit period later.
                        rx_cnt <= half_len(divisor_value, MODULATION_PATTERN[next_rx_idx], 1'b0);
                        rx_half <= 1'b0;
                        rx_idx <= next_rx_idx;
                        rx_pos <= '0;
                        rx_bit_no <= rx_bit_no + 4'h1;
                        if (rx_bit_no != 4'h0 && rx_bit_no <= (DATA_LEN7 ? 4'h7 : 4'h8)) begin
                            rx_word[3'(rx_bit_no - 4'h1)] <= rx_bit_val;
                        end
                        if (rx_bit_no == nbits - 4'h1) begin
                            rx_state <= RX_PUSH;
                        end
                    end else if (baud_tick) begin
                        rx_pos <= rx_pos_next;
                        if (rx_cnt > 16'h0001) begin
                            rx_cnt <= rx_cnt - 16'h0001;
                        end else begin
                            rx_cnt <= half_len(divisor_value, 1'b0, 1'b1);
                            rx_half <= 1'b1;
                        end
                    end
                end
                RX_PUSH: begin
                    // The receiver waits here while the buffer is full.
                    if (rx_in.ready) begin
                        rx_state <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    uteb_fifo2 #(.WIDTH(BYTE_W)) u_rx_buf (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .in_s(rx_in.snk),
        .out_s(rx_out.src)
    );

    // ---------------- Checks ----------------
    logic [DIV_W:0] tx_len; // Ticks elapsed in the current transmit bit.
    logic rx_voted; // The third sample of this bit has been taken.

    // Counts ticks of each transmitted bit for the length check.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_len <= '0;
            rx_voted <= 1'b0;
        end else begin
            if (tx_load || tx_bit_end) begin
                tx_len <= '0;
            end else if (baud_tick) begin
                tx_len <= tx_len + 17'h00001;
            end
            if (rx_bit_end || rx_state != RX_BITS) begin
                rx_voted <= 1'b0;
            end else if (rx_third) begin
                rx_voted <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    a_write_clears_ready:
        assert property (TXBUF_WRITE |=> !TX_BUFFER_READY_FLAG) else $error("ready stayed set");
    a_load_starts_frame:
        assert property (tx_load |=> tx_state == TX_ACTIVE && !SERIAL_TX_PIN)
        else $error("load did not start a frame");
    a_load_on_tick:
        assert property (tx_load |-> tx_bit_end || en_rise) else $error("load off bit tick");
    a_disabled_holds:
        assert property (!TX_ENABLE_BIT && !hold_commit |-> !tx_load)
        else $error("disabled character sent");
    a_reenable_loads:
        assert property (en_rise && hold_full && tx_state == TX_IDLE |-> tx_load)
        else $error("re-enable did not load");
    a_frame_finishes:
        assert property (tx_state == TX_ACTIVE && !tx_bit_end |=> tx_state == TX_ACTIVE)
        else $error("frame cut short");
    a_bit_length:
        assert property (tx_state == TX_ACTIVE && tx_bit_end |->
            tx_len + 17'h00001 == {1'b0, divisor_value} + {16'h0000, MODULATION_PATTERN[tx_idx]})
        else $error("bit length wrong");
    a_half_reload:
        assert property (tx_half_end && !tx_load |=>
            tx_half && tx_cnt == half_len($past(divisor_value), 1'b0, 1'b1))
        else $error("half not reloaded");
    a_mod_restart:
        assert property (tx_load |=> tx_idx == 3'h0 && !tx_half) else $error("pointer not reset");
    a_mod_step:
        assert property (tx_state == TX_ACTIVE && tx_bit_end && tx_left != 4'h1 |=>
            tx_idx == $past(tx_idx) + 3'h1) else $error("pointer did not step");
    a_start_abort:
        assert property (rx_third && rx_bit_no == 4'h0 && rx_maj |=> rx_state == RX_IDLE)
        else $error("noisy start accepted");
    a_rx_voted:
        assert property (rx_bit_end |-> rx_voted) else $error("bit ended without vote");

    c_back_to_back: cover property (tx_state == TX_ACTIVE && tx_load);
    c_start_abort: cover property (rx_third && rx_bit_no == 4'h0 && rx_maj);
    c_rx_stall: cover property (rx_state == RX_PUSH && !rx_in.ready);
    c_reenable: cover property (en_rise && hold_full && tx_load);

endmodule : uteb_top

// file: uteb_remote.sv
// Remote serial device: checks each received bit cycle by cycle and sends frames back.
// Assumes a bit lasts (divisor + modulation bit) baud ticks of tick_div clocks each.
`timescale 1ns/1ps
module uteb_remote (
    input wire logic clk,
    input wire logic line_in,
    input wire logic [15:0] n_div,
    input wire logic [7:0] mod_pat,
    input wire logic [3:0] n_bits,
    input wire logic [3:0] tick_div,
    output logic line_out
);
    logic [7:0] got_q[$]; // Characters taken from the line.
    int bad_bits = 0; // Cycles where the line moved inside a bit, and frames with a low stop bit.
    logic [11:0] sh; // Bits of the frame being taken.
    logic v; // Level at the first cycle of the bit.
    initial line_out = 1'h1;
    // Each bit must hold one level for its whole modulated length.
    always begin
        @(negedge line_in);
        for (int i = 0; i < n_bits; i++) begin
            for (int c = 0; c < (n_div + mod_pat[i % 8]) * tick_div; c++) begin
                @(negedge clk);
                if (c == 0) v = line_in;
                if (line_in !== v) bad_bits++;
                sh[i] = v;
            end
        end
        // The last bit of every frame is a stop bit and must be high.
        if (sh[n_bits - 4'h1] !== 1'h1) bad_bits++;
        got_q.push_back(sh[8:1]);
    end
    // Sends one 8N1 frame with the same modulated bit lengths; called just after an edge.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            line_out = f[i];
            repeat ((n_div + mod_pat[i % 8]) * tick_div) @(posedge clk);
            #1;
        end
        repeat (4 * n_div) @(posedge clk);
        #1;
    endtask : send
    // Pulls the line low for two clocks only, a false start the receiver must drop.
    task automatic glitch();
        line_out = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        line_out = 1'h1;
        repeat (4 * n_div) @(posedge clk);
        #1;
    endtask : glitch
endmodule : uteb_remote

// file: tb_uteb_top.sv
// Testbench of the transmit-enable and bit-timing block facing a remote serial device.
// Assumes the design package, the design and the remote model are compiled first.
`timescale 1ns/1ps
module tb_uteb_top;
    import uteb_pkg::*;
    logic clock = 1'h0, reset_n = 1'h0, sel = 1'h0, ext_tick = 1'h0, par_en = 1'h0;
    logic par_even = 1'h0, two_stop = 1'h0, tx_en = 1'h0, wr = 1'h0, rx_ready = 1'h0;
    logic len7 = 1'h0; // Seven data bits.
    logic [15:0] div = 16'h0008;
    logic [7:0] pat = 8'h00, wdata = 8'h00;
    logic [3:0] n_bits = 4'hA, tick_div = 4'h1, tick_cnt = 4'h0;
    logic ready_flag, empty_flag, tx_pin, rx_pin, rx_valid;
    logic [7:0] rx_data;
    int miscompares = 0, n_compared = 0;
    uteb_top DUT (.CLOCK(clock), .RESET_N(reset_n), .BAUD_SOURCE_SELECT(sel),
        .BAUD_EXT_TICK(ext_tick), .DIVISOR_LOW_BYTE(div[7:0]), .DIVISOR_HIGH_BYTE(div[15:8]),
        .MODULATION_PATTERN(pat), .DATA_LEN7(len7), .PARITY_ENABLE(par_en),
        .PARITY_EVEN(par_even), .TWO_STOP(two_stop), .TX_ENABLE_BIT(tx_en), .TXBUF_WRITE(wr),
        .TXBUF_DATA(wdata), .TX_BUFFER_READY_FLAG(ready_flag), .TX_EMPTY_FLAG(empty_flag),
        .SERIAL_TX_PIN(tx_pin), .SERIAL_RX_PIN(rx_pin), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_READY(rx_ready));
    uteb_remote u_remote (.clk(clock), .line_in(tx_pin), .n_div(div), .mod_pat(pat),
        .n_bits(n_bits), .tick_div(tick_div), .line_out(rx_pin));
    always #5 clock = ~clock;
    // External baud ticks, one clock wide, every tick_div clocks.
    always @(posedge clock) begin
        #1;
        tick_cnt = (tick_cnt >= tick_div - 4'h1) ? 4'h0 : tick_cnt + 4'h1;
        ext_tick = (tick_cnt == 4'h0);
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic put(input logic [7:0] d);
        wr = 1'h1;
        wdata = d;
        @(posedge clock);
        #1;
        wr = 1'h0;
    endtask : put
    // Waits for a finished frame and an idle transmitter, then checks the character.
    task automatic pop(input logic [7:0] exp);
        for (int t = 0; t < 40000 && (u_remote.got_q.size() == 0 || empty_flag !== 1'h1); t++) begin
            @(posedge clock);
            #1;
        end
        if (u_remote.got_q.size() == 0) cmp(~exp, exp);
        else cmp(u_remote.got_q.pop_front(), exp);
    endtask : pop
    task automatic end_sim;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic t_reset;
        cmp({6'h00, ready_flag, empty_flag}, 8'h03);
        cmp({6'h00, tx_pin, rx_valid}, 8'h02);
    endtask : t_reset
    // Four patterns with frames of ten and eleven bits; frames over eight bits wrap the modulation pattern.
    task automatic t_modulation;
        logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
        tx_en = 1'h1;
        for (int k = 0; k < 4; k++) begin
            pat = pats[k];
            par_en = k[0];
            two_stop = k[1];
            len7 = k[0] & k[1];
            par_even = len7;
            n_bits = 4'hA + {3'h0, par_en} + {3'h0, two_stop} - {3'h0, len7};
            // The remote's byte is parity over seven data bits: D5 sent 7E reads back 55.
            put(len7 ? 8'hD5 : 8'h55);
            pop(8'h55);
        end
        {par_en, par_even, len7, two_stop, n_bits} = {4'h0, 4'hA};
    endtask : t_modulation
    task automatic t_disabled;
        tx_en = 1'h0;
        put(8'hA5);
        repeat (300) @(posedge clock);
        #1;
        cmp({5'h00, ready_flag, empty_flag, 1'(u_remote.got_q.size())}, 8'h00);
        tx_en = 1'h1;
        @(posedge clock);
        #1;
        cmp({7'h00, tx_pin}, 8'h00);
        pop(8'hA5);
    endtask : t_disabled
    task automatic t_back_to_back;
        put(8'h3C);
        for (int t = 0; t < 100 && ready_flag !== 1'h1; t++) begin
            @(posedge clock);
            #1;
        end
        put(8'hC3);
        tx_en = 1'h0;
        pop(8'h3C);
        pop(8'hC3);
        tx_en = 1'h1;
    endtask : t_back_to_back
    task automatic t_timing;
        div = 16'h0104;
        put(8'h96);
        pop(8'h96);
        {div, pat, sel, tick_div} = {16'h0008, 8'h55, 1'h1, 4'h3};
        put(8'h55);
        pop(8'h55);
        {pat, sel, tick_div} = {8'h00, 1'h0, 4'h1};
    endtask : t_timing
    // A false start is dropped; two characters fill the stalled buffer, then drain in order.
    task automatic t_receive;
        u_remote.glitch();
        u_remote.send(8'hC3);
        u_remote.send(8'h5A);
        cmp({7'h00, rx_valid}, 8'h01);
        cmp(rx_data, 8'hC3);
        rx_ready = 1'h1;
        @(posedge clock);
        #1;
        cmp(rx_data, 8'h5A);
        @(posedge clock);
        #1;
        rx_ready = 1'h0;
        cmp({7'h00, rx_valid}, 8'h00);
    endtask : t_receive
    initial begin
        #500000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock);
        #1;
        reset_n = 1'h1;
        t_reset();
        t_modulation();
        t_disabled();
        t_back_to_back();
        t_timing();
        t_receive();
        cmp({7'h00, 1'(u_remote.bad_bits != 0)}, 8'h00);
        end_sim();
    end
endmodule : tb_uteb_top
